// *** core/dpo_pkg.sv ***
// Purpose: Shared constants for the drop path overhead status block
// Assumes: Register indices sit at byte address index * 4
// Notes:   Local registers sit from index 0x060 upward
`default_nettype none

package dpo_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          IDX_W         = 10;
  localparam int          DATA_W        = 32;

  // Register indices, byte address is four times the index
  localparam logic [9:0]  IDX_RX_K4     = 10'h042;
  localparam logic [9:0]  IDX_RX_OBITS  = 10'h043;
  localparam logic [9:0]  IDX_LAT_TC    = 10'h05c;
  localparam logic [9:0]  IDX_LIVE_TC   = 10'h05d;
  localparam logic [9:0]  IDX_LAT_PATH  = 10'h05e;
  localparam logic [9:0]  IDX_LIVE_PATH = 10'h05f;
  localparam logic [9:0]  IDX_CTRL      = 10'h060;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h061;
  localparam logic [9:0]  IDX_IRQ_CLR   = 10'h062;
  localparam logic [9:0]  IDX_IRQ_EN    = 10'h063;
  localparam logic [9:0]  IDX_EXP_BASE  = 10'h064;
  localparam int          EXP_WORDS     = 4;

  // Control register fields
  localparam int          CTRL_FILT_BIT = 0;
  localparam int          CTRL_SIZE_BIT = 1;
  localparam int          CTRL_CMP_BIT  = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;

  // Live alarm bit positions
  localparam int          ALM_RDIP      = 7;
  localparam int          ALM_RDIC      = 6;
  localparam int          ALM_LOL       = 3;
  localparam int          ALM_TIM       = 2;

  // Enhanced remote defect code, transmitted bits 5..7 at byte bits 3..1
  localparam int          K4_CODE_HI    = 3;
  localparam int          K4_CODE_LO    = 1;
  localparam logic [2:0]  K4_PAYLOAD    = 3'h2;
  localparam logic [2:0]  K4_CONNECT    = 3'h6;

  // O-bits, transmitted bits 3..6 at byte bits 5..2
  localparam int          OBIT_HI       = 5;
  localparam int          OBIT_LO       = 2;

  // Filter lengths in consecutive events, trace message length in bytes
  localparam int          FILT_SHORT    = 5;
  localparam int          FILT_LONG     = 10;
  localparam int          TRACE_LEN     = 16;

  // Interrupt status bits
  localparam int          IRQ_W         = 6;
  localparam int          IRQ_RDIP      = 0;
  localparam int          IRQ_RDIC      = 1;
  localparam int          IRQ_LOL       = 2;
  localparam int          IRQ_TIM       = 3;
  localparam int          IRQ_K4        = 4;
  localparam int          IRQ_TC        = 5;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : dpo_pkg

`default_nettype wire

// *** core/dpo_defect_filter.sv ***
// Purpose: Consecutive-event filter for one remote defect alarm
// Assumes: One sample pulse per received code
// Notes:   Same count sets and clears
`default_nettype none

module dpo_defect_filter #(
  parameter int SHORT = 5,
  parameter int LONG  = 10
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic sample,
  input  wire logic detect,
  input  wire logic long_sel,
  output var  logic alarm_q
);

  localparam int CW = $clog2(LONG + 1);

  if (SHORT < 1 || LONG < SHORT)
  begin : g_bad_len
    $error("dpo_defect_filter: bad filter lengths");
  end

  logic [CW-1:0] cnt_q;
  wire  [CW-1:0] target  = long_sel ? CW'(LONG) : CW'(SHORT);
  wire  [CW-1:0] cnt_inc = cnt_q + CW'(1);
  wire           differ  = detect != alarm_q;
  wire           flip    = sample && differ && (cnt_inc >= target);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q   <= '0;
      alarm_q <= 1'b0;
    end
    else if (sample)
    begin
      cnt_q   <= (differ && !flip) ? cnt_inc : '0;
      alarm_q <= alarm_q ^ flip;
    end
  end

endmodule : dpo_defect_filter

`default_nettype wire

// *** core/dpo_trace_mon.sv ***
// Purpose: Path trace lock and mismatch monitor
// Assumes: Message start byte has its top bit set
// Notes:   All state but the stored message held at reset while disabled
`default_nettype none

module dpo_trace_mon #(
  parameter int LEN = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             enable,
  input  wire logic             byte_valid,
  input  wire logic [7:0]       byte_in,
  input  wire logic [LEN*8-1:0] expected,
  output var  logic             loss_of_lock,
  output var  logic             mismatch_q
);

  localparam int PW = $clog2(LEN);
  localparam int RW = $clog2(LEN + 1);

  if (LEN < 2 || (1 << PW) != LEN)
  begin : g_bad_len
    $error("dpo_trace_mon: LEN must be a power of two");
  end

  logic [7:0]       msg_q [LEN];
  logic [LEN*8-1:0] msg_flat;
  logic [PW-1:0]    pos_q;
  logic [RW-1:0]    rep_q;
  logic             locked_q;
  logic             lost_q;
  logic             diff_q;

  genvar gi;
  generate
    for (gi = 0; gi < LEN; gi++)
    begin : g_flat
      assign msg_flat[gi*8 +: 8] = msg_q[gi];
    end
  endgenerate

  wire [PW-1:0] wpos      = byte_in[7] ? '0 : pos_q + PW'(1);
  wire          repeat_ok = msg_q[wpos] == byte_in;
  wire          exp_ok    = expected[wpos*8 +: 8] == byte_in;
  wire          msg_end   = wpos == PW'(LEN - 1);
  wire          gain      = !locked_q && repeat_ok && (rep_q == RW'(LEN - 1));
  wire          lose      = locked_q && !repeat_ok;
  wire          tim_set   = locked_q && repeat_ok && msg_end && (diff_q || !exp_ok);
  wire          tim_clr   = gain && lost_q && (msg_flat == expected);

  assign loss_of_lock = enable && !locked_q;

  always_ff @(posedge aclk)
  begin
    if (byte_valid)
      msg_q[wpos] <= byte_in;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      pos_q      <= '0;
      rep_q      <= '0;
      locked_q   <= 1'b0;
      lost_q     <= 1'b1;
      diff_q     <= 1'b0;
      mismatch_q <= 1'b0;
    end
    else if (byte_valid)
    begin
      pos_q      <= wpos;
      rep_q      <= repeat_ok ? ((rep_q == RW'(LEN)) ? rep_q : rep_q + RW'(1)) : '0;
      locked_q   <= (locked_q || gain) && !lose;
      lost_q     <= (lost_q || lose) && !gain;
      diff_q     <= locked_q && !msg_end && (diff_q || !exp_ok);
      mismatch_q <= tim_set || (mismatch_q && !tim_clr);
    end
  end

endmodule : dpo_trace_mon

`default_nettype wire

// *** core/dpo_status.sv ***
// Purpose: Drop path overhead status registers with AXI4-Lite access
// Assumes: Drop bus decode feeds one-cycle strobes on aclk
// Notes:   Reading a latched register clears its latched bits
//
// What this block does
// - Payload defect alarm rises when received code bits 5 to 7 read 010.
// - Connectivity defect alarm rises when received code bits 5 to 7 read 110.
// - A filter-length bit picks how many consecutive events set and clear both.
// - Trace alarms run only with 16-byte size chosen and compare enabled.
// - Trace loss of lock stays high until the message repeats unchanged for 16 consecutive bytes.
// - Trace mismatch sets when the stable message differs for one message time.
// - Trace mismatch clears after a loss and relock onto the expected message, or when trace is disabled.
// - The receive K4 register shows the received byte, bit 7 as first sent bit.
// - The O-bit register holds two nibbles taken from the two control bytes.
// - Both O-bit nibbles are updated together from the same frame.
// - Latched path bits 7-6 and 3-2 copy the same live alarm bits.
// - Latched tandem bits 7-1 copy the same live tandem alarm bits.
// - Unused bits 5-4 and 1-0 of live and latched path registers read zero.
// - Bit 0 of the latched tandem register carries no meaning.
`default_nettype none

module dpo_status
  import dpo_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [dpo_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output var  logic                       awready,
  input  wire logic [dpo_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output var  logic                       wready,
  output var  logic [1:0]                 bresp,
  output var  logic                       bvalid,
  input  wire logic                       bready,
  input  wire logic [dpo_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output var  logic                       arready,
  output var  logic [dpo_pkg::DATA_W-1:0] rdata,
  output var  logic [1:0]                 rresp,
  output var  logic                       rvalid,
  input  wire logic                       rready,
  input  wire logic                       k4_valid,
  input  wire logic [7:0]                 k4_byte,
  input  wire logic                       jc_valid,
  input  wire logic [7:0]                 jc1_byte,
  input  wire logic [7:0]                 jc2_byte,
  input  wire logic                       j2_valid,
  input  wire logic [7:0]                 j2_byte,
  input  wire logic [7:1]                 tc_live_alarms,
  output var  logic                       irq
);

  import dpo_pkg::*;

  // Bus state
  logic [ADDR_W-1:0]    aw_addr_q;
  logic [DATA_W-1:0]    w_data_q;
  logic [3:0]           w_strb_q;
  logic                 aw_full_q;
  logic                 w_full_q;

  // Register state
  logic [2:0]           ctrl_q;
  logic [7:0]           rx_k4_q;
  logic [7:0]           rx_obits_q;
  logic [7:1]           lat_tc_q;
  logic [7:0]           lat_path_q;
  logic [7:0]           live_prev_q;
  logic [7:1]           tc_prev_q;
  logic [IRQ_W-1:0]     irq_stat_q;
  logic [IRQ_W-1:0]     irq_en_q;
  logic [DATA_W-1:0]    exp_q [EXP_WORDS];
  logic [TRACE_LEN*8-1:0] exp_flat;

  // Alarm sources
  logic                 rdip;
  logic                 rdic;
  logic                 lol;
  logic                 tim;

  // Write channel decode
  wire                  aw_take   = awvalid && awready;
  wire                  w_take    = wvalid && wready;
  wire                  do_write  = aw_full_q && w_full_q && !bvalid;
  wire [IDX_W-1:0]      w_idx     = aw_addr_q[ADDR_W-1:2];
  wire                  w_ctrl    = do_write && (w_idx == IDX_CTRL);
  wire                  w_clr     = do_write && (w_idx == IDX_IRQ_CLR);
  wire                  w_en      = do_write && (w_idx == IDX_IRQ_EN);
  wire [IDX_W-1:0]      w_exp_off = w_idx - IDX_EXP_BASE;
  wire                  w_exp     = do_write && (w_idx >= IDX_EXP_BASE)
                                    && (w_exp_off < IDX_W'(EXP_WORDS));
  wire                  w_mapped  = w_ctrl || w_clr || w_en || w_exp;
  wire                  lane0     = w_strb_q[0];

  // Read channel decode
  wire                  ar_take   = arvalid && arready;
  wire [IDX_W-1:0]      r_idx     = araddr[ADDR_W-1:2];
  wire                  rd_lat_tc = ar_take && (r_idx == IDX_LAT_TC);
  wire                  rd_lat_pa = ar_take && (r_idx == IDX_LAT_PATH);
  wire [IDX_W-1:0]      r_exp_off = r_idx - IDX_EXP_BASE;
  wire                  r_exp     = (r_idx >= IDX_EXP_BASE)
                                    && (r_exp_off < IDX_W'(EXP_WORDS));

  // Control fields
  wire                  filt_long = ctrl_q[CTRL_FILT_BIT];
  wire                  trace_on  = !ctrl_q[CTRL_SIZE_BIT] && ctrl_q[CTRL_CMP_BIT];

  // Received code decode
  wire [2:0]            k4_code   = k4_byte[K4_CODE_HI:K4_CODE_LO];
  wire                  det_pay   = k4_code == K4_PAYLOAD;
  wire                  det_con   = k4_code == K4_CONNECT;

  // Live path alarm word, unused bits tied low
  wire [7:0]            live_path = {rdip, rdic, 2'b00, lol, tim, 2'b00};
  wire [7:0]            path_mask = 8'hcc;

  // Events for the interrupt status
  wire [IRQ_W-1:0]      irq_ev;
  wire [IRQ_W-1:0]      irq_stat_d;

  assign irq_ev[IRQ_RDIP] = rdip && !live_prev_q[ALM_RDIP];
  assign irq_ev[IRQ_RDIC] = rdic && !live_prev_q[ALM_RDIC];
  assign irq_ev[IRQ_LOL]  = lol && !live_prev_q[ALM_LOL];
  assign irq_ev[IRQ_TIM]  = tim && !live_prev_q[ALM_TIM];
  assign irq_ev[IRQ_K4]   = k4_valid && (k4_byte != rx_k4_q);
  assign irq_ev[IRQ_TC]   = |(tc_live_alarms & ~tc_prev_q);

  assign irq_stat_d = (irq_stat_q & ~(w_clr ? w_data_q[IRQ_W-1:0] : '0)) | irq_ev;

  genvar gi;
  generate
    for (gi = 0; gi < EXP_WORDS; gi++)
    begin : g_exp
      assign exp_flat[gi*DATA_W +: DATA_W] = exp_q[gi];
    end
  endgenerate

  // Remote defect filters
  dpo_defect_filter #(
    .SHORT (FILT_SHORT),
    .LONG  (FILT_LONG)
  ) u_filt_payload (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .sample   (k4_valid),
    .detect   (det_pay),
    .long_sel (filt_long),
    .alarm_q  (rdip)
  );

  dpo_defect_filter #(
    .SHORT (FILT_SHORT),
    .LONG  (FILT_LONG)
  ) u_filt_connect (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .sample   (k4_valid),
    .detect   (det_con),
    .long_sel (filt_long),
    .alarm_q  (rdic)
  );

  // Path trace monitor
  dpo_trace_mon #(
    .LEN (TRACE_LEN)
  ) u_trace (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (trace_on),
    .byte_valid   (j2_valid),
    .byte_in      (j2_byte),
    .expected     (exp_flat),
    .loss_of_lock (lol),
    .mismatch_q   (tim)
  );

  // Write address and data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready   <= 1'b0;
      end
      else if (do_write)
        aw_full_q <= 1'b0;
      else if (bvalid && bready)
        awready <= 1'b1;
      if (w_take)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_full_q <= 1'b1;
        wready   <= 1'b0;
      end
      else if (do_write)
        w_full_q <= 1'b0;
      else if (bvalid && bready)
        wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Software written registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= CTRL_RESET;
      irq_en_q <= '0;
    end
    else
    begin
      if (w_ctrl && lane0)
        ctrl_q <= w_data_q[2:0];
      if (w_en && lane0)
        irq_en_q <= w_data_q[IRQ_W-1:0];
    end
  end

  generate
    for (gi = 0; gi < EXP_WORDS; gi++)
    begin : g_exp_wr
      genvar bl;
      for (bl = 0; bl < 4; bl++)
      begin : g_lane
        always_ff @(posedge aclk)
        begin
          if (!aresetn)
            exp_q[gi][bl*8 +: 8] <= '0;
          else if (w_exp && (w_exp_off == IDX_W'(gi)) && w_strb_q[bl])
            exp_q[gi][bl*8 +: 8] <= w_data_q[bl*8 +: 8];
        end
      end
    end
  endgenerate

  // Received overhead capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_k4_q    <= '0;
      rx_obits_q <= '0;
    end
    else
    begin
      if (k4_valid)
        rx_k4_q <= k4_byte;
      if (jc_valid)
        rx_obits_q <= {jc2_byte[OBIT_HI:OBIT_LO], jc1_byte[OBIT_HI:OBIT_LO]};
    end
  end

  // Latched alarms, a new alarm wins over the read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lat_path_q  <= '0;
      lat_tc_q    <= '0;
      live_prev_q <= '0;
      tc_prev_q   <= '0;
    end
    else
    begin
      lat_path_q  <= ((rd_lat_pa ? 8'h00 : lat_path_q) | live_path) & path_mask;
      lat_tc_q    <= (rd_lat_tc ? 7'h00 : lat_tc_q) | tc_live_alarms;
      live_prev_q <= live_path;
      tc_prev_q   <= tc_live_alarms;
    end
  end

  // Interrupt status and output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq        <= |(irq_stat_d & irq_en_q);
    end
  end

  // Read data select
  logic [DATA_W-1:0] rd_val;
  logic              rd_hit;

  always_comb
  begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (r_idx)
      IDX_RX_K4:     rd_val[7:0] = rx_k4_q;
      IDX_RX_OBITS:  rd_val[7:0] = rx_obits_q;
      IDX_LAT_TC:    rd_val[7:0] = {lat_tc_q, 1'b0};
      IDX_LIVE_TC:   rd_val[7:0] = {tc_live_alarms, 1'b0};
      IDX_LAT_PATH:  rd_val[7:0] = lat_path_q;
      IDX_LIVE_PATH: rd_val[7:0] = live_path;
      IDX_CTRL:      rd_val[2:0] = ctrl_q;
      IDX_IRQ_STAT:  rd_val[IRQ_W-1:0] = irq_stat_q;
      IDX_IRQ_EN:    rd_val[IRQ_W-1:0] = irq_en_q;
      default:
      begin
        if (r_exp)
          rd_val = exp_q[r_exp_off[1:0]];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_val;
      rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : dpo_status

`default_nettype wire

// *** dv/dpo_props.sv ***
// Purpose: Port checker for the drop path overhead status block
// Assumes: One read and one write under way at a time
// Notes:   Helper indices track the last taken addresses
`default_nettype none

module dpo_props
  import dpo_pkg::*;
(
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic [dpo_pkg::ADDR_W-1:0] awaddr,
  input wire logic                       awvalid,
  input wire logic                       awready,
  input wire logic                       wvalid,
  input wire logic                       wready,
  input wire logic [1:0]                 bresp,
  input wire logic                       bvalid,
  input wire logic                       bready,
  input wire logic [dpo_pkg::ADDR_W-1:0] araddr,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic [dpo_pkg::DATA_W-1:0] rdata,
  input wire logic                       rvalid,
  input wire logic                       rready,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] ar_idx_q;
  logic [9:0] aw_idx_q;

  always_ff @(posedge aclk)
  begin
    if (arvalid && arready) ar_idx_q <= araddr[11:2];
    if (awvalid && awready) aw_idx_q <= awaddr[11:2];
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_B_LATENCY: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  AST_W_STALL: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during answer");
  AST_R_LATENCY: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken during answer");
  AST_PATH_ZERO: assert property (
    rvalid && (ar_idx_q == IDX_LIVE_PATH || ar_idx_q == IDX_LAT_PATH)
    |-> rdata[5:4] == 2'h0 && rdata[1:0] == 2'h0)
    else $error("unused path bits set");
  AST_TC_BIT0: assert property (rvalid && ar_idx_q == IDX_LAT_TC |-> !rdata[0])
    else $error("latched tandem bit0 set");
  AST_RO_WRITE: assert property (
    bvalid && (aw_idx_q == IDX_RX_K4 || aw_idx_q == IDX_LIVE_PATH) |-> bresp == RESP_SLVERR)
    else $error("read-only write accepted");

  cover property (arvalid && arready && araddr[11:2] == IDX_LAT_PATH);
  cover property (bvalid && bready && bresp == RESP_SLVERR);
  cover property ($rose(irq));
endmodule : dpo_props

bind dpo_status dpo_props i_dpo_props (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .irq(irq)
);

`default_nettype wire

// *** dv/dpo_drop_src.sv ***
// Purpose: Drop bus source model for the selected tributary
// Assumes: Strobes are one cycle wide on aclk
// Notes:   Data lines show the inverse value between strobes
`default_nettype none

module dpo_drop_src (
  input  wire logic       aclk,
  output var  logic       k4_valid,
  output var  logic [7:0] k4_byte,
  output var  logic       jc_valid,
  output var  logic [7:0] jc1_byte,
  output var  logic [7:0] jc2_byte,
  output var  logic       j2_valid,
  output var  logic [7:0] j2_byte,
  output var  logic [7:1] tc_live_alarms
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {k4_valid, jc_valid, j2_valid} = 3'h0;
    {k4_byte, jc1_byte, jc2_byte, j2_byte} = 32'h0;
    tc_live_alarms = 7'h00;
  end

  task automatic k4(input logic [7:0] b, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      k4_valid <= 1'b1;
      k4_byte <= b;
      @(posedge aclk);
      k4_valid <= 1'b0;
      k4_byte <= ~b;
    end
  endtask : k4

  task automatic jc(input logic [7:0] a, input logic [7:0] b);
    @(posedge aclk);
    jc_valid <= 1'b1;
    {jc1_byte, jc2_byte} <= {a, b};
    @(posedge aclk);
    jc_valid <= 1'b0;
    {jc1_byte, jc2_byte} <= ~{a, b};
  endtask : jc

  task automatic j2(input logic [127:0] m, input int reps, input int gap);
    for (int r = 0; r < reps * 16; r++)
    begin
      @(posedge aclk);
      j2_valid <= 1'b1;
      j2_byte <= m[127 - 8 * (r % 16) -: 8];
      @(posedge aclk);
      j2_valid <= 1'b0;
      j2_byte <= ~m[127 - 8 * (r % 16) -: 8];
      repeat (gap) @(posedge aclk);
    end
  endtask : j2

  task automatic tc(input logic [7:1] a);
    @(posedge aclk);
    tc_live_alarms <= a;
  endtask : tc
endmodule : dpo_drop_src

`default_nettype wire

// *** dv/tb_dpo_status.sv ***
// Purpose: Self-checking bench for the drop path overhead status block
// Assumes: Register reads return the 8-bit value in lane 0
// Notes:   Scenarios run in order, trace before defect codes
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %h expected %h", $time, a, b); end end

module tb_dpo_status;
  import dpo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] EXP = 128'h80414243444546474849_4a4b4c4d4e4f;
  localparam logic [127:0] BAD = 128'h80414243444546474849_4a4b4c4d4e50;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  wire logic         k4_valid, jc_valid, j2_valid;
  wire logic [7:0]   k4_byte, jc1_byte, jc2_byte, j2_byte;
  wire logic [7:1]   tc_live_alarms;
  int                miscompares = 0;
  int                compares = 0;
  int                lag = 0;

  dpo_status i_dpo_status (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .k4_valid(k4_valid), .k4_byte(k4_byte), .jc_valid(jc_valid), .jc1_byte(jc1_byte),
    .jc2_byte(jc2_byte), .j2_valid(j2_valid), .j2_byte(j2_byte),
    .tc_live_alarms(tc_live_alarms), .irq(irq));
  dpo_drop_src i_dpo_drop_src (.aclk(aclk), .k4_valid(k4_valid), .k4_byte(k4_byte),
    .jc_valid(jc_valid), .jc1_byte(jc1_byte), .jc2_byte(jc2_byte), .j2_valid(j2_valid),
    .j2_byte(j2_byte), .tc_live_alarms(tc_live_alarms));

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
    bit ok;
    ok = 0;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid} <= {i, 2'h0, d, 4'hf, 2'h3};
    bready <= (lag == 0);
    for (int n = 1; n < 100 && !ok; n++)
    begin
      @(posedge aclk);
      ok = (bvalid === 1'b1 && bready === 1'b1);
      if (!ok && awready) awvalid <= 1'b0;
      if (!ok && wready) wvalid <= 1'b0;
      if (!ok && n >= lag) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (!ok)
    begin
      miscompares++;
      stop_test();
    end
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [9:0] i, output logic [31:0] d, input logic [1:0] er);
    bit ok;
    ok = 0;
    @(posedge aclk);
    {araddr, arvalid} <= {i, 2'h0, 1'b1};
    rready <= (lag == 0);
    for (int n = 1; n < 100 && !ok; n++)
    begin
      @(posedge aclk);
      ok = (rvalid === 1'b1 && rready === 1'b1);
      if (!ok && arready) arvalid <= 1'b0;
      if (!ok && n >= lag) rready <= 1'b1;
    end
    d = rdata;
    rready <= 1'b0;
    if (!ok)
    begin
      miscompares++;
      stop_test();
    end
    `CHK(rresp, er)
  endtask : rd

  task automatic chk(input logic [9:0] i, input logic [7:0] e);
    logic [31:0] d;
    rd(i, d, RESP_OKAY);
    `CHK(d[7:0], e)
  endtask : chk

  task automatic t_regs();
    logic [31:0] d;
    lag = 3;
    chk(IDX_CTRL, {5'h0, CTRL_RESET});
    chk(IDX_RX_K4, 8'h00);
    wr(IDX_RX_K4, 32'h55, RESP_SLVERR);
    rd(10'h3ff, d, RESP_SLVERR);
    lag = 0;
  endtask : t_regs

  task automatic t_obits();
    i_dpo_drop_src.jc(8'h28, 8'h14);
    chk(IDX_RX_OBITS, 8'h5a);
    i_dpo_drop_src.jc(8'h14, 8'h28);
    chk(IDX_RX_OBITS, 8'ha5);
  endtask : t_obits

  task automatic t_trace();
    logic [31:0] w;
    for (int k = 0; k < EXP_WORDS; k++)
    begin
      for (int l = 0; l < 4; l++)
        w[8 * l +: 8] = EXP[127 - 8 * (4 * k + l) -: 8];
      wr(IDX_EXP_BASE + 10'(k), w, RESP_OKAY);
    end
    wr(IDX_CTRL, 32'h6, RESP_OKAY);
    i_dpo_drop_src.j2(BAD, 3, 0);
    chk(IDX_LIVE_PATH, 8'h00);
    wr(IDX_CTRL, 32'h4, RESP_OKAY);
    chk(IDX_LIVE_PATH, 8'h08);
    i_dpo_drop_src.j2(EXP, 3, 0);
    chk(IDX_LIVE_PATH, 8'h00);
    i_dpo_drop_src.j2(BAD, 4, 2);
    chk(IDX_LIVE_PATH, 8'h04);
    i_dpo_drop_src.j2(EXP, 4, 0);
    chk(IDX_LIVE_PATH, 8'h00);
    chk(IDX_LAT_PATH, 8'h0c);
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
  endtask : t_trace

  task automatic t_defect();
    logic [31:0] d;
    wr(IDX_IRQ_CLR, 32'h3f, RESP_OKAY);
    wr(IDX_IRQ_EN, 32'h0, RESP_OKAY);
    i_dpo_drop_src.k4(8'h04, FILT_SHORT - 1);
    chk(IDX_LIVE_PATH, 8'h00);
    i_dpo_drop_src.k4(8'h04, 1);
    chk(IDX_LIVE_PATH, 8'h80);
    chk(IDX_RX_K4, 8'h04);
    `CHK(irq, 1'b0)
    wr(IDX_IRQ_EN, 32'h1 << IRQ_RDIP, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_CLR, 32'h1 << IRQ_RDIP, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(IDX_IRQ_CLR, d, RESP_SLVERR);
    wr(IDX_CTRL, 32'h1, RESP_OKAY);
    i_dpo_drop_src.k4(8'h0c, FILT_LONG - 1);
    chk(IDX_LIVE_PATH, 8'h80);
    i_dpo_drop_src.k4(8'h0c, 1);
    chk(IDX_LIVE_PATH, 8'h40);
    chk(IDX_LAT_PATH, 8'hc0);
    chk(IDX_LAT_PATH, 8'h40);
  endtask : t_defect

  task automatic t_tandem();
    i_dpo_drop_src.tc(7'h55);
    chk(IDX_LIVE_TC, 8'haa);
    i_dpo_drop_src.tc(7'h00);
    chk(IDX_LAT_TC, 8'haa);
    chk(IDX_LAT_TC, 8'h00);
  endtask : t_tandem

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_obits();
    t_trace();
    t_defect();
    t_tandem();
    stop_test();
  end
endmodule : tb_dpo_status

`default_nettype wire
